/* File: src/hcc_core.sv */
`default_nettype none
// Summary of operation
// - Mode write 0x07 leaves standby, selects calibration
// - Go starts calibration, cleared when done
// - Calibration overwrites its result registers
// - LRA-only inputs ignored for ERM
// - Fault flag in status reports calibration outcome
// - Settings kept through standby and enable low
// - Fuse memory accepts a single programming
// - Program bit burns fuses; status reads 1
// - Soft reset reloads fuse-backed registers
// - Open loop scaled by overdrive limit, mid-zero
// - Negative drive brakes ERM, flips LRA phase
// - Realtime amplitude signed or unsigned per bit
// - Closed loop follows rated, capped by limit
// - Bidirectional below mid-scale gives zero target
// - Closed-loop bidirectional is the reset default
// - Closed loop brakes automatically from back-EMF
// - Mode 5 drives realtime amplitude continuously
// - Go or trigger starts stored waveform playback
// - Type bit and open-loop bit choose ERM open
// - Registers answer behind bus target 0x5a
module hcc_core import hcc_pkg::*; #(
  parameter int CAL_STEP_US = 100000
) (
  input  wire logic       mclk,           // System clock
  input  wire logic       rst_n,          // Power-on reset
  input  wire logic [7:0] reg_addr,       // Register offset
  input  wire logic [7:0] reg_wdata,      // Write data
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  output logic      [7:0] reg_rdata,      // Read data, next cycle
  input  wire logic       en_pin,         // Enable pin
  input  wire logic       trig_pin,       // External trigger pin
  input  wire logic [7:0] bemf_level,     // Back-EMF measure
  input  wire logic [7:0] seq_amp,        // Sequencer amplitude
  input  wire logic       seq_done,       // Sequencer finished
  input  wire logic       otp_blank_n,    // Fuse array blank
  output logic      [7:0] drive_level,    // Drive magnitude
  output logic            drive_active,   // Output stage on
  output logic            erm_brake,      // ERM counter-rotation
  output logic            lra_phase_flip, // LRA 180 phase shift
  output logic            cal_busy,       // Calibration running
  output logic            play_start      // Sequencer start pulse
);
  localparam int CAL_STEP_CYC = CAL_STEP_US * CLK_FREQ_MHZ;

  if (CAL_STEP_US < 1 || CAL_STEP_CYC > 32'h3fffffff) begin : g_bad
    $error("hcc_core: CAL_STEP_US out of range");
  end

  hcc_otp_if otp ();

  logic [1:0]  s1_r, s2_r, s3_r, pin_r;
  logic        trig_prev_r;
  logic [7:0]  mode_r, rtp_r, rated_r, clamp_r, comp_r, bemfres_r;
  logic [7:0]  fbctl_r, ctl1_r, ctl2_r, ctl3_r, ctl4_r;
  logic        soft_rst_r, reload_r, go_r, fault_r, playing_r;
  hcc_cal_type cal_state_r;
  logic [31:0] cal_cnt_r;
  logic [7:0]  gap_cnt_r, peak_r;
  logic [7:0]  rdata_r, drive_r;
  logic        active_r, brake_r, flip_r, start_r;
  logic        do_rst, device_on, en_q, trig_q, is_lra, go_wr, go_set;
  logic        cal_run, cal_done, open_loop, trig_start;
  hcc_mode_type mode_q;
  logic [7:0]  u, tgt, amp_nxt, gap_load;
  logic        pos, neg_nxt;
  logic [8:0]  mag;
  logic [16:0] prod;
  logic [11:0] acc;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r  <= 2'h0;
      s2_r  <= 2'h0;
      s3_r  <= 2'h0;
      pin_r <= 2'h0;
    end else begin
      s1_r  <= {trig_pin, en_pin};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      // Change accepted only once stages two and three agree
      pin_r <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_r);
    end
  end

  assign en_q      = pin_r[0];
  assign trig_q    = pin_r[1];
  assign do_rst    = !rst_n || soft_rst_r;
  assign mode_q    = hcc_mode_type'(mode_r[2:0]);
  assign device_on = en_q && !mode_r[MODE_STBY_BIT];
  assign is_lra    = fbctl_r[FB_TYPE_BIT];
  assign go_wr     = reg_wr && (reg_addr == ADDR_GO);
  assign go_set    = go_wr && reg_wdata[GO_BIT];
  assign cal_run   = (cal_state_r == CAL_RUN);
  assign cal_done  = (cal_state_r == CAL_DONE);
  assign open_loop = is_lra ? ctl3_r[CTL3_LRA_OL_BIT]
                            : ctl3_r[CTL3_ERM_OL_BIT];

  // ----------------------------------------
  // Configuration and fuse-backed registers
  // ----------------------------------------
  // Standby and enable never touch these, only resets do
  always_ff @(posedge mclk) begin
    if (do_rst) begin
      mode_r     <= MODE_RST;
      rtp_r      <= 8'h00;
      rated_r    <= RATED_RST;
      clamp_r    <= CLAMP_RST;
      comp_r     <= COMP_RST;
      bemfres_r  <= BEMF_RST;
      fbctl_r    <= FBCTL_RST;
      ctl1_r     <= CTL1_RST;
      ctl2_r     <= CTL2_RST;
      ctl3_r     <= CTL3_RST;
      ctl4_r     <= CTL4_RST;
      soft_rst_r <= 1'b0;
      reload_r   <= 1'b1;
    end else begin
      reload_r <= 1'b0;
      if (reload_r && otp.burned) begin
        {fbctl_r, bemfres_r, comp_r, clamp_r, rated_r} <= otp.rdata;
      end else if (cal_done) begin
        comp_r       <= (peak_r < rated_r) ? 8'(rated_r - peak_r) : 8'h00;
        bemfres_r    <= peak_r;
        fbctl_r[1:0] <= peak_r[7:6];
      end else if (reg_wr) begin
        unique case (reg_addr)
          ADDR_MODE: begin
            mode_r     <= {1'b0, reg_wdata[6:0]};
            soft_rst_r <= reg_wdata[MODE_SRST_BIT];
          end
          ADDR_RTP:   rtp_r   <= reg_wdata;
          ADDR_RATED: rated_r <= reg_wdata;
          ADDR_CLAMP: clamp_r <= reg_wdata;
          ADDR_COMP:  comp_r  <= reg_wdata;
          ADDR_BEMF:  bemfres_r <= reg_wdata;
          ADDR_FBCTL: fbctl_r <= reg_wdata;
          ADDR_CTL1:  ctl1_r  <= reg_wdata;
          ADDR_CTL2:  ctl2_r  <= reg_wdata;
          ADDR_CTL3:  ctl3_r  <= reg_wdata;
          ADDR_CTL4:  ctl4_r  <= {reg_wdata[7:3], 3'h0};
          default: ;
        endcase
      end
    end
  end

  // Burn request carries the live contents of the backed registers
  assign otp.prog  = reg_wr && (reg_addr == ADDR_CTL4)
                     && reg_wdata[CTL4_OTP_PG_BIT];
  assign otp.wdata = {fbctl_r, bemfres_r, comp_r, clamp_r, rated_r};

  hcc_otp #(
    .WORDS   (OTP_WORDS)
  ) u_otp (
    .mclk    (mclk),
    .blank_n (otp_blank_n),
    .port    (otp)
  );

  // ----------------------------------------
  // Go bit
  // ----------------------------------------
  // A software set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (do_rst) begin
      go_r <= 1'b0;
    end else if (go_set) begin
      go_r <= 1'b1;
    end else if (go_wr) begin
      go_r <= 1'b0;
    end else if (cal_done || (playing_r && seq_done)) begin
      go_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Calibration engine
  // ----------------------------------------
  // LRA sampling uses its timing fields; ERM uses a fixed gap
  assign gap_load = is_lra ? 8'({ctl1_r[4:0], 3'h0} + {6'h0, ctl2_r[5:4]}
                               + {6'h0, ctl2_r[3:2]} + {6'h0, ctl2_r[1:0]})
                           : ERM_SAMPLE_GAP;

  always_ff @(posedge mclk) begin
    if (do_rst) begin
      cal_state_r <= CAL_IDLE;
      cal_cnt_r   <= 32'h0;
      gap_cnt_r   <= 8'h00;
      peak_r      <= 8'h00;
    end else begin
      unique case (cal_state_r)
        CAL_IDLE: begin
          if (go_r && device_on && mode_q == MODE_AUTOCAL) begin
            cal_state_r <= CAL_RUN;
            cal_cnt_r   <= 32'((32'(ctl4_r[5:4]) + 32'h1) * CAL_STEP_CYC);
            gap_cnt_r   <= gap_load;
            peak_r      <= 8'h00;
          end
        end
        CAL_RUN: begin
          cal_cnt_r <= cal_cnt_r - 32'h1;
          if (gap_cnt_r == 8'h00) begin
            gap_cnt_r <= gap_load;
            if (bemf_level > peak_r) begin
              peak_r <= bemf_level;
            end
          end else begin
            gap_cnt_r <= gap_cnt_r - 8'h01;
          end
          if (cal_cnt_r <= 32'h1) begin
            cal_state_r <= CAL_DONE;
          end
        end
        CAL_DONE: cal_state_r <= CAL_IDLE;
        default:  cal_state_r <= CAL_IDLE;
      endcase
    end
  end

  // No motion seen, or motion at or beyond the clamp, is a fault
  always_ff @(posedge mclk) begin
    if (do_rst) begin
      fault_r <= 1'b0;
    end else if (cal_done) begin
      fault_r <= (peak_r == 8'h00) || (peak_r >= clamp_r);
    end else if (cal_state_r == CAL_IDLE && cal_run == 1'b0 && go_r
                 && device_on && mode_q == MODE_AUTOCAL) begin
      fault_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Stored waveform playback start
  // ----------------------------------------
  assign trig_start = (mode_q == MODE_EXT_EDGE || mode_q == MODE_EXT_LEVEL)
                      && trig_q && !trig_prev_r;

  always_ff @(posedge mclk) begin
    if (do_rst) begin
      trig_prev_r <= 1'b0;
      playing_r   <= 1'b0;
      start_r     <= 1'b0;
    end else begin
      trig_prev_r <= trig_q;
      start_r     <= 1'b0;
      if (device_on && !playing_r &&
          ((go_set && !go_r && mode_q == MODE_INT_TRIG) || trig_start)) begin
        playing_r <= 1'b1;
        start_r   <= 1'b1;
      end else if (seq_done || (go_wr && !go_set)) begin
        playing_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Amplitude interpretation
  // ----------------------------------------
  always_comb begin
    // Signed input is re-centred so mid-scale sits at 0x80
    u = playing_r ? seq_amp
                  : (ctl3_r[CTL3_SIGN_BIT] ? rtp_r : rtp_r ^ MID_SCALE);
    pos     = (u >= MID_SCALE);
    mag     = pos ? 9'({1'b0, u} - {1'b0, MID_SCALE})
                  : 9'({1'b0, MID_SCALE} - {1'b0, u});
    prod    = 17'h0;
    tgt     = 8'h00;
    acc     = 12'h0;
    amp_nxt = 8'h00;
    neg_nxt = 1'b0;
    if (open_loop && !cal_run) begin
      prod    = 17'(mag * clamp_r);
      amp_nxt = prod[14:7];
      neg_nxt = !pos;
    end else begin
      if (cal_run) begin
        tgt = rated_r;
      end else if (ctl2_r[CTL2_BIDIR_BIT]) begin
        prod = 17'(mag * rated_r);
        tgt  = pos ? prod[14:7] : 8'h00;
      end else begin
        prod = 17'(u * rated_r);
        tgt  = prod[15:8];
      end
      if (bemf_level > tgt) begin
        acc     = 12'(bemf_level - tgt)
                  * (12'(fbctl_r[6:4]) + 12'h1);
        neg_nxt = 1'b1;
      end else begin
        acc = 12'(tgt) + 12'(tgt - bemf_level)
              * (12'(fbctl_r[3:2]) + 12'h1);
      end
      // Overdrive and braking stay under the limit level
      amp_nxt = (acc > 12'(clamp_r)) ? clamp_r : acc[7:0];
    end
  end

  // ----------------------------------------
  // Drive outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (do_rst) begin
      active_r <= 1'b0;
      drive_r  <= 8'h00;
      brake_r  <= 1'b0;
      flip_r   <= 1'b0;
    end else begin
      active_r <= device_on
                  && (mode_q == MODE_REALTIME || playing_r || cal_run);
      if (device_on
          && (mode_q == MODE_REALTIME || playing_r || cal_run)) begin
        drive_r <= amp_nxt;
        brake_r <= neg_nxt && !is_lra;
        flip_r  <= neg_nxt && is_lra;
      end else begin
        drive_r <= 8'h00;
        brake_r <= 1'b0;
        flip_r  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // This port sits behind the bus target decode at 0x5a
  always_ff @(posedge mclk) begin
    if (do_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS: rdata_r <= {DEVICE_ID, 1'b0, fault_r, 2'h0,
                                 cal_run};
        ADDR_MODE:   rdata_r <= mode_r;
        ADDR_RTP:    rdata_r <= rtp_r;
        ADDR_GO:     rdata_r <= {7'h00, go_r};
        ADDR_RATED:  rdata_r <= rated_r;
        ADDR_CLAMP:  rdata_r <= clamp_r;
        ADDR_COMP:   rdata_r <= comp_r;
        ADDR_BEMF:   rdata_r <= bemfres_r;
        ADDR_FBCTL:  rdata_r <= fbctl_r;
        ADDR_CTL1:   rdata_r <= ctl1_r;
        ADDR_CTL2:   rdata_r <= ctl2_r;
        ADDR_CTL3:   rdata_r <= ctl3_r;
        ADDR_CTL4:   rdata_r <= {ctl4_r[7:3], otp.burned, 2'h0};
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata      = rdata_r;
  assign drive_level    = drive_r;
  assign drive_active   = active_r;
  assign erm_brake      = brake_r;
  assign lra_phase_flip = flip_r;
  assign cal_busy       = (cal_state_r == CAL_RUN);
  assign play_start     = start_r;
endmodule // hcc_core
`default_nettype wire

/* File: shared/hcc_pkg.sv */
`default_nettype none
package hcc_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int          CLK_FREQ_MHZ   = 10;
  localparam logic [7:0]  ERM_SAMPLE_GAP = 8'h20;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h01;
  localparam logic [7:0] ADDR_RTP    = 8'h02;
  localparam logic [7:0] ADDR_GO     = 8'h0c;
  localparam logic [7:0] ADDR_RATED  = 8'h16;
  localparam logic [7:0] ADDR_CLAMP  = 8'h17;
  localparam logic [7:0] ADDR_COMP   = 8'h18;
  localparam logic [7:0] ADDR_BEMF   = 8'h19;
  localparam logic [7:0] ADDR_FBCTL  = 8'h1a;
  localparam logic [7:0] ADDR_CTL1   = 8'h1b;
  localparam logic [7:0] ADDR_CTL2   = 8'h1c;
  localparam logic [7:0] ADDR_CTL3   = 8'h1d;
  localparam logic [7:0] ADDR_CTL4   = 8'h1e;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int STS_BUSY_BIT    = 0;
  localparam int STS_FAULT_BIT   = 3;
  localparam int MODE_SRST_BIT   = 7;
  localparam int MODE_STBY_BIT   = 6;
  localparam int GO_BIT          = 0;
  localparam int FB_TYPE_BIT     = 7;
  localparam int CTL2_BIDIR_BIT  = 7;
  localparam int CTL3_ERM_OL_BIT = 5;
  localparam int CTL3_SIGN_BIT   = 3;
  localparam int CTL3_LRA_OL_BIT = 0;
  localparam int CTL4_OTP_ST_BIT = 2;
  localparam int CTL4_OTP_PG_BIT = 0;
  // ----------------------------------------
  // Reset values and constants
  // ----------------------------------------
  localparam logic [7:0] MODE_RST   = 8'h40;
  localparam logic [7:0] RATED_RST  = 8'h3f;
  localparam logic [7:0] CLAMP_RST  = 8'h90;
  localparam logic [7:0] COMP_RST   = 8'h0d;
  localparam logic [7:0] BEMF_RST   = 8'h6c;
  localparam logic [7:0] FBCTL_RST  = 8'h36;
  localparam logic [7:0] CTL1_RST   = 8'h13;
  localparam logic [7:0] CTL2_RST   = 8'hf5;
  localparam logic [7:0] CTL3_RST   = 8'h08;
  localparam logic [7:0] CTL4_RST   = 8'h20;
  localparam logic [7:0] MID_SCALE  = 8'h80;
  localparam logic [2:0] DEVICE_ID  = 3'h5; // Arbitrary value
  localparam int         OTP_WORDS  = 5;
  localparam int         OTP_BITS   = 8 * OTP_WORDS;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_INT_TRIG  = 3'h0,
    MODE_EXT_EDGE  = 3'h1,
    MODE_EXT_LEVEL = 3'h2,
    MODE_ANALOG    = 3'h3,
    MODE_VIBE      = 3'h4,
    MODE_REALTIME  = 3'h5,
    MODE_DIAG      = 3'h6,
    MODE_AUTOCAL   = 3'h7
  } hcc_mode_type;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_RUN  = 2'h1,
    CAL_DONE = 2'h2
  } hcc_cal_type;
endpackage
`default_nettype wire

/* File: shared/hcc_otp_if.sv */
`default_nettype none
interface hcc_otp_if import hcc_pkg::*; ();
  logic                prog;
  logic [OTP_BITS-1:0] wdata;
  logic [OTP_BITS-1:0] rdata;
  logic                burned;
  modport ctl (output prog, output wdata, input rdata, input burned);
  modport mem (input prog, input wdata, output rdata, output burned);
endinterface
`default_nettype wire

/* File: src/hcc_otp.sv */
`default_nettype none
module hcc_otp import hcc_pkg::*; #(
  parameter int WORDS = OTP_WORDS
) (
  input  wire logic mclk,    // System clock
  input  wire logic blank_n, // Factory blank of fuse array
  hcc_otp_if.mem    port     // Program and read port
);
  logic [OTP_BITS-1:0] cells_r;
  logic [OTP_BITS-1:0] rdata_r;
  logic                burned_r;

  if (WORDS != OTP_WORDS) begin : g_bad_words
    $error("hcc_otp: WORDS must match the backed register count");
  end

  // ----------------------------------------
  // Fuse cells, burned once only
  // ----------------------------------------
  // Not cleared by rst_n: the fuses outlive every reset of the logic
  always_ff @(posedge mclk) begin
    if (!blank_n) begin
      cells_r  <= '0;
      burned_r <= 1'b0;
    end else if (port.prog && !burned_r) begin
      cells_r  <= port.wdata;
      burned_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!blank_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= cells_r;
    end
  end

  assign port.rdata  = rdata_r;
  assign port.burned = burned_r;
endmodule // hcc_otp
`default_nettype wire

/* File: tb/hcc_host.sv */
`default_nettype none
module hcc_host (
  input  wire logic       mclk,      // System clock
  output logic      [7:0] reg_addr,  // Register offset
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd     // Read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles, launched just after an edge
  // ----------------------------------------
  task automatic op(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  // Every sequence ends here so no strobe lingers
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask
endmodule // hcc_host
`default_nettype wire

/* File: tb/hcc_chk.sv */
`default_nettype none
module hcc_chk import hcc_pkg::*; #(
  parameter int CAL_STEP_US = 100000
) (
  input wire logic       mclk,           // Clock
  input wire logic       rst_n,          // Reset
  input wire logic [7:0] reg_addr,       // Offset
  input wire logic [7:0] reg_wdata,      // Wdata
  input wire logic       reg_wr,         // Write
  input wire logic       reg_rd,         // Read
  input wire logic [7:0] reg_rdata,      // Rdata
  input wire logic       en_pin,         // Enable
  input wire logic       trig_pin,       // Trigger
  input wire logic [7:0] bemf_level,     // Back-EMF
  input wire logic [7:0] seq_amp,        // Seq amp
  input wire logic       seq_done,       // Seq done
  input wire logic       otp_blank_n,    // Fuse blank
  input wire logic [7:0] drive_level,    // Drive
  input wire logic       drive_active,   // Drive on
  input wire logic       erm_brake,      // Brake
  input wire logic       lra_phase_flip, // Flip
  input wire logic       cal_busy,       // Busy
  input wire logic       play_start      // Start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Fuse status history, survives rst_n
  // ----------------------------------------
  logic rd_ctl4_r;
  logic burned_r;
  always_ff @(posedge mclk) begin
    rd_ctl4_r <= reg_rd && (reg_addr == ADDR_CTL4);
  end
  always_ff @(posedge mclk) begin
    if (!otp_blank_n) begin
      burned_r <= 1'b0;
    end else if (rd_ctl4_r && reg_rdata[CTL4_OTP_ST_BIT]) begin
      burned_r <= 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rdata_idle; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("rdata without read");
  property p_go_busy;
    reg_rd && reg_addr == ADDR_GO && cal_busy |=> reg_rdata[GO_BIT];
  endproperty
  a_go_busy: assert property (p_go_busy)
    else $error("go low while busy");
  property p_sts_busy;
    reg_rd && reg_addr == ADDR_STATUS && cal_busy
      |=> reg_rdata[STS_BUSY_BIT] && reg_rdata[7:5] == DEVICE_ID;
  endproperty
  a_sts_busy: assert property (p_sts_busy)
    else $error("status busy bad");
  property p_fuse_sticky;
    rd_ctl4_r && burned_r |-> reg_rdata[CTL4_OTP_ST_BIT];
  endproperty
  a_fuse_sticky: assert property (p_fuse_sticky)
    else $error("fuse status lost");
  property p_prog_wo;
    reg_rd && reg_addr == ADDR_CTL4 |=> !reg_rdata[CTL4_OTP_PG_BIT];
  endproperty
  a_prog_wo: assert property (p_prog_wo)
    else $error("program bit read");
  property p_srst_clear;
    reg_rd && reg_addr == ADDR_MODE |=> !reg_rdata[MODE_SRST_BIT];
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("soft reset reads 1");
  property p_rtp_echo;
    (reg_wr && reg_addr == ADDR_RTP)
      ##1 (reg_rd && !reg_wr && reg_addr == ADDR_RTP)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rtp_echo: assert property (p_rtp_echo)
    else $error("amplitude not kept");
  property p_unmapped;
    reg_rd && reg_addr > ADDR_CTL4 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read data");
  property p_play_pulse; play_start |=> !play_start; endproperty
  a_play_pulse: assert property (p_play_pulse)
    else $error("start too long");
  property p_flag_excl; erm_brake |-> !lra_phase_flip; endproperty
  a_flag_excl: assert property (p_flag_excl)
    else $error("both flags high");
  property p_play_nocal; play_start |-> !cal_busy; endproperty
  a_play_nocal: assert property (p_play_nocal)
    else $error("play in calib");
endmodule // hcc_chk
bind hcc_core hcc_chk #(.CAL_STEP_US(CAL_STEP_US)) hcc_chk_inst (.*);
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench import hcc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       mclk = 1'b0;
  logic       rst_n, en_pin, trig_pin, seq_done, otp_blank_n;
  logic [7:0] bemf_level, seq_amp, u, m;
  wire  [7:0] reg_addr, reg_wdata;
  wire        reg_wr, reg_rd;
  logic [7:0] reg_rdata, drive_level;
  logic       drive_active, erm_brake, lra_phase_flip;
  logic       cal_busy, play_start;
  logic       rd_q = 1'b0;
  logic [7:0] exp_q[$];
  int         num_errors = 0;
  int         checks = 0;
  int         seed, n;
  logic [7:0] rst_a[9] = '{ADDR_STATUS, ADDR_MODE, ADDR_RATED,
    ADDR_CLAMP, ADDR_FBCTL, ADDR_CTL2, ADDR_CTL3, ADDR_CTL4, 8'h50};
  logic [7:0] rst_v[9] = '{{DEVICE_ID, 5'h00}, MODE_RST, RATED_RST,
    CLAMP_RST, FBCTL_RST, CTL2_RST, CTL3_RST, CTL4_RST, 8'h00};
  always #50 mclk = ~mclk;
  hcc_host hcc_host_inst (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  hcc_core #(.CAL_STEP_US(2)) hcc_core_inst (.*);
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hcc_host_inst.op(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    hcc_host_inst.op(1'b0, a, 8'h00);
    exp_q.push_back(e);
  endtask
  task automatic idle(input int k);
    hcc_host_inst.idle(k);
  endtask
  task automatic wait_play();
    n = 0;
    while (play_start !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("play start", {7'h0, play_start}, 8'h01);
    chk("calib busy", {7'h0, cal_busy}, 8'h00);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        num_errors++;
      end else begin
        chk("read data", reg_rdata, exp_q.pop_front());
      end
    end
  end
  task automatic wait_busy(input logic v);
    n = 0;
    while (cal_busy !== v && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n == 400) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic cal(input logic [7:0] b, input logic [7:0] sts);
    bemf_level <= b;
    wr(ADDR_GO, 8'h01);
    idle(1);
    wait_busy(1'b1);
    rd(ADDR_GO, 8'h01);
    rd(ADDR_STATUS, {DEVICE_ID, 5'h01});
    idle(1);
    wait_busy(1'b0);
    idle(2);
    rd(ADDR_GO, 8'h00);
    rd(ADDR_STATUS, sts);
    idle(1);
  endtask
  task automatic drv(input logic [7:0] a, input logic [7:0] lv,
                     input logic f, input logic br, input logic fl);
    wr(ADDR_RTP, a);
    rd(ADDR_RTP, a);
    idle(3);
    @(negedge mclk);
    chk("drive level", drive_level, lv);
    chk("drive on", {7'h0, drive_active}, 8'h01);
    if (f) begin
      chk("ERM brake", {7'h0, erm_brake}, {7'h0, br});
      chk("LRA flip", {7'h0, lra_phase_flip}, {7'h0, fl});
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    seed = 32'hb56d;
    rst_n = 1'b0;
    en_pin = 1'b0;
    trig_pin = 1'b0;
    seq_done = 1'b0;
    otp_blank_n = 1'b0;
    bemf_level = 8'h00;
    seq_amp = 8'h80;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    otp_blank_n <= 1'b1;
    idle(2);
    foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
    en_pin <= 1'b1;
    wr(ADDR_MODE, 8'h07);
    wr(ADDR_RATED, 8'h60);
    wr(ADDR_FBCTL, 8'h28);
    wr(ADDR_CTL2, 8'hb5);
    wr(ADDR_CTL4, 8'h30);
    idle(1);
    cal(8'h40, {DEVICE_ID, 5'h00});
    rd(ADDR_BEMF, 8'h40);
    rd(ADDR_COMP, 8'h20);
    rd(ADDR_FBCTL, 8'h29);
    cal(8'h00, {DEVICE_ID, 5'h08});
    en_pin <= 1'b0;
    wr(ADDR_MODE, 8'h40);
    rd(ADDR_RATED, 8'h60);
    rd(ADDR_COMP, 8'h60);
    wr(ADDR_CTL4, 8'h31);
    rd(ADDR_CTL4, 8'h34);
    wr(ADDR_RATED, 8'h11);
    wr(ADDR_MODE, 8'h80);
    idle(3);
    rd(ADDR_RATED, 8'h60);
    rd(ADDR_FBCTL, 8'h28);
    rd(ADDR_CTL4, 8'h24);
    wr(ADDR_RATED, 8'h22);
    wr(ADDR_CTL4, 8'h01);
    wr(ADDR_MODE, 8'h80);
    idle(3);
    rd(ADDR_RATED, 8'h60);
    en_pin <= 1'b1;
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_CTL3, 8'h28);
    drv(8'hc0, 8'h48, 1'b1, 1'b0, 1'b0);
    drv(8'h40, 8'h48, 1'b1, 1'b1, 1'b0);
    drv(8'h80, 8'h00, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      u = 8'($random(seed));
      trig_pin <= 1'($random(seed));
      seq_amp <= 8'($random(seed));
      m = (u >= 8'h80) ? u - 8'h80 : 8'h80 - u;
      drv(u, 8'((32'(m) * CLAMP_RST) >> 7), 1'b1, u < 8'h80, 1'b0);
    end
    wr(ADDR_CTL3, 8'h21);
    drv(8'h40, 8'h48, 1'b1, 1'b0, 1'b0);
    drv(8'hc0, 8'h48, 1'b1, 1'b1, 1'b0);
    wr(ADDR_FBCTL, 8'ha8);
    drv(8'hc0, 8'h48, 1'b1, 1'b0, 1'b1);
    wr(ADDR_CTL3, 8'h08);
    wr(ADDR_FBCTL, 8'h28);
    drv(8'h40, 8'h00, 1'b0, 1'b0, 1'b0);
    drv(8'hc0, 8'h90, 1'b0, 1'b0, 1'b0);
    wr(ADDR_CTL2, 8'h75);
    bemf_level <= 8'h30;
    drv(8'h80, 8'h30, 1'b0, 1'b0, 1'b0);
    bemf_level <= 8'h50;
    drv(8'h80, 8'h60, 1'b0, 1'b0, 1'b0);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_GO, 8'h01);
    idle(1);
    wait_play();
    @(posedge mclk);
    seq_done <= 1'b1;
    @(posedge mclk);
    seq_done <= 1'b0;
    idle(2);
    rd(ADDR_GO, 8'h00);
    trig_pin <= 1'b0;
    wr(ADDR_MODE, 8'h01);
    idle(6);
    trig_pin <= 1'b1;
    wait_play();
    idle(1);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge mclk);
    if (exp_q.size() != 0) begin
      num_errors++;
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
